// *** rpc_pkg.sv ***
package rpc_pkg;
	// Clock and timeout figures; the count rounds up because the timeout is a least wait.
	localparam int CLK_PERIOD_NS = 25;
	localparam int CFG_TIMEOUT_NS = 50000;
	localparam int CFG_TIMEOUT_CYC = (CFG_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 12;

	// Enhanced configuration address layout.
	localparam int ECAM_W = 28;
	localparam int ECAM_BUS_LSB = 20;
	localparam int ECAM_DEV_LSB = 15;
	localparam int ECAM_FN_LSB = 12;
	localparam int ECAM_REG_LSB = 2;

	// Bus responses and completion status codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] CPL_SC = 3'h0;
	localparam logic [2:0] CPL_UR = 3'h1;

	// BAR reset value and the all-ones error read data.
	localparam logic [31:0] BAR_BASE_RST = 32'h0000_0000;
	localparam logic [31:0] ALL_ONES = 32'hffff_ffff;

	// Configuration request toward the link or the local block.
	typedef struct packed {
		logic is_type1;
		logic we;
		logic [7:0] bus;
		logic [4:0] dev;
		logic [2:0] fn;
		logic [9:0] reg_num;
		logic [3:0] be;
		logic [31:0] data;
	} rpc_cfg_req_t;

	// Completion returned from the link.
	typedef struct packed {
		logic [2:0] status;
		logic [31:0] data;
	} rpc_cpl_t;

	// Access sequencer states.
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ACCEPT = 5'h02,
		ST_LOCAL = 5'h04,
		ST_LINK = 5'h08,
		ST_RESP = 5'h10
	} rpc_state_t;
endpackage

// *** rpc_timer.sv ***
`timescale 1ns/100ps
module rpc_timer #(
	parameter int W = 12,
	parameter logic [11:0] LIMIT = 12'h7d0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Control.
	input wire logic start,
	input wire logic stop,
	// One-cycle pulse when the limit is reached.
	output logic expired
);
	logic [W-1:0] count;
	logic running;

	// The counter runs from start until stop or expiry; a stop in the expiry cycle wins.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			count <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end
		else
		begin
			expired <= 1'b0;
			if (start)
			begin
				count <= '0;
				running <= 1'b1;
			end
			else if (stop)
				running <= 1'b0;
			else if (running)
			begin
				if (count == LIMIT - 12'h001)
				begin
					running <= 1'b0;
					expired <= 1'b1;
				end
				else
					count <= count + 12'h001;
			end
		end
	end

	chk_timer_bound: assert property (@(posedge clk) disable iff (!rst_n)
		running |-> count < LIMIT)
		else $error("Timeout counter ran past its limit.");
endmodule // rpc_timer

// *** rpc_root_port_cfg.sv ***
`timescale 1ns/100ps
module rpc_root_port_cfg
	import rpc_pkg::*;
#(
	parameter bit BAR_EN = 1'b1,
	parameter bit XLATE_EN = 1'b1,
	parameter int BAR_SIZE_LOG2 = 20,
	parameter bit RX_DECODE = 1'b0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Configuration access slave, write channels.
	input wire logic [rpc_pkg::ECAM_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Configuration access slave, read channels.
	input wire logic [rpc_pkg::ECAM_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Own Type 1 header values and command bits.
	input wire logic [7:0] primary_bus,
	input wire logic [7:0] secondary_bus,
	input wire logic [7:0] subordinate_bus,
	input wire logic master_enable,
	input wire logic [15:0] requester_id,
	// Local self-configuration port.
	output logic loc_valid,
	output rpc_pkg::rpc_cfg_req_t loc_req,
	input wire logic loc_ack,
	input wire logic [31:0] loc_rdata,
	// Link configuration requests and completions.
	output logic link_req_valid,
	output rpc_pkg::rpc_cfg_req_t link_req,
	input wire logic link_req_ready,
	input wire logic cpl_valid,
	input wire rpc_pkg::rpc_cpl_t cpl,
	output logic timeout_irq,
	// Power limit message.
	output logic pwr_msg_valid,
	output logic [15:0] pwr_msg_rid,
	input wire logic pwr_msg_ready,
	// Received packets and their forwarding.
	input wire logic rx_valid,
	input wire logic [31:0] rx_addr,
	input wire logic [31:0] rx_data,
	input wire logic bar_base_load,
	input wire logic [31:0] bar_base_wdata,
	input wire logic [31:0] xlate_base,
	output logic fwd_valid,
	output logic [31:0] fwd_addr,
	output logic [31:0] fwd_data,
	// Received interrupt messages.
	input wire logic rx_int_msg,
	output logic int_fifo_push,
	output logic int_decode_set
);
	import rpc_pkg::*;

	rpc_state_t state;
	logic is_write;
	logic sent;
	logic tmr_expired;
	logic me_prev;
	logic [31:0] bar_base;
	logic [ECAM_W-1:0] in_addr;
	logic [7:0] in_bus;
	logic in_primary;
	logic in_type0;
	logic in_type1;
	logic cpl_take;
	logic bar_hit;
	logic [31:0] bar_mask;

	// Split the presented address into its fields for routing.
	assign in_addr = is_write ? awaddr : araddr;
	assign in_bus = in_addr[ECAM_W-1:ECAM_BUS_LSB];
	assign in_primary = (in_bus == primary_bus);
	assign in_type0 = !in_primary && (in_bus == secondary_bus);
	assign in_type1 = !in_primary && (in_bus > secondary_bus) && (in_bus <= subordinate_bus);
	assign cpl_take = (state == ST_LINK) && sent && cpl_valid;

	// Sequencer: one access at a time, read wins a tie with write.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			is_write <= 1'b0;
			sent <= 1'b0;
			arready <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= '0;
			loc_valid <= 1'b0;
			loc_req <= '0;
			link_req_valid <= 1'b0;
			link_req <= '0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					// Ready is raised only once both write channels are valid, so an
					// address is never taken without its data.
					if (arvalid)
					begin
						arready <= 1'b1;
						is_write <= 1'b0;
						state <= ST_ACCEPT;
					end
					else if (awvalid && wvalid)
					begin
						awready <= 1'b1;
						wready <= 1'b1;
						is_write <= 1'b1;
						state <= ST_ACCEPT;
					end
				end
				ST_ACCEPT:
				begin
					arready <= 1'b0;
					awready <= 1'b0;
					wready <= 1'b0;
					loc_req.is_type1 <= in_type1;
					link_req.is_type1 <= in_type1;
					loc_req.we <= is_write;
					link_req.we <= is_write;
					loc_req.bus <= in_bus;
					link_req.bus <= in_bus;
					loc_req.dev <= in_addr[ECAM_BUS_LSB-1:ECAM_DEV_LSB];
					link_req.dev <= in_addr[ECAM_BUS_LSB-1:ECAM_DEV_LSB];
					loc_req.fn <= in_addr[ECAM_DEV_LSB-1:ECAM_FN_LSB];
					link_req.fn <= in_addr[ECAM_DEV_LSB-1:ECAM_FN_LSB];
					loc_req.reg_num <= in_addr[ECAM_FN_LSB-1:ECAM_REG_LSB];
					link_req.reg_num <= in_addr[ECAM_FN_LSB-1:ECAM_REG_LSB];
					loc_req.be <= is_write ? wstrb : 4'hf;
					link_req.be <= is_write ? wstrb : 4'hf;
					loc_req.data <= wdata;
					link_req.data <= wdata;
					if (in_primary)
					begin
						loc_valid <= 1'b1;
						state <= ST_LOCAL;
					end
					else if (in_type0 || in_type1)
					begin
						link_req_valid <= 1'b1;
						sent <= 1'b0;
						state <= ST_LINK;
					end
					else
					begin
						// Out of range: nothing reaches the link.
						bvalid <= is_write;
						rvalid <= !is_write;
						bresp <= RESP_SLVERR;
						rresp <= RESP_SLVERR;
						rdata <= ALL_ONES;
						state <= ST_RESP;
					end
				end
				ST_LOCAL:
				begin
					if (loc_ack)
					begin
						loc_valid <= 1'b0;
						bvalid <= is_write;
						rvalid <= !is_write;
						bresp <= RESP_OKAY;
						rresp <= RESP_OKAY;
						rdata <= loc_rdata;
						state <= ST_RESP;
					end
				end
				ST_LINK:
				begin
					if (link_req_valid && link_req_ready)
					begin
						link_req_valid <= 1'b0;
						sent <= 1'b1;
					end
					if (cpl_take)
					begin
						bvalid <= is_write;
						rvalid <= !is_write;
						state <= ST_RESP;
						if (cpl.status == CPL_SC)
						begin
							bresp <= RESP_OKAY;
							rresp <= RESP_OKAY;
							rdata <= cpl.data;
						end
						else if (cpl.status == CPL_UR)
						begin
							// A missing device reads as all ones; a write to it fails.
							bresp <= RESP_SLVERR;
							rresp <= RESP_OKAY;
							rdata <= ALL_ONES;
						end
						else
						begin
							bresp <= RESP_SLVERR;
							rresp <= RESP_SLVERR;
							rdata <= ALL_ONES;
						end
					end
					else if (tmr_expired)
					begin
						bvalid <= is_write;
						rvalid <= !is_write;
						bresp <= RESP_SLVERR;
						rresp <= RESP_SLVERR;
						rdata <= ALL_ONES;
						state <= ST_RESP;
					end
				end
				ST_RESP:
				begin
					if ((bvalid && bready) || (rvalid && rready))
					begin
						bvalid <= 1'b0;
						rvalid <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Timer runs from the cycle the link takes the request until the completion.
	rpc_timer #(
		.W(TMR_W),
		.LIMIT(TMR_W'(CFG_TIMEOUT_CYC))
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(state == ST_LINK && link_req_valid && link_req_ready),
		.stop(cpl_take),
		.expired(tmr_expired)
	);

	// Timeout indication is a pulse beside the error response.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			timeout_irq <= 1'b0;
		else
			timeout_irq <= tmr_expired && !cpl_take && (state == ST_LINK);
	end

	// Power limit message on the rising edge of Master Enable; a new edge wins over the
	// acceptance of the previous message so it is not lost.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			me_prev <= 1'b0;
			pwr_msg_valid <= 1'b0;
			pwr_msg_rid <= '0;
		end
		else
		begin
			me_prev <= master_enable;
			if (master_enable && !me_prev)
			begin
				pwr_msg_valid <= 1'b1;
				pwr_msg_rid <= requester_id;
			end
			else if (pwr_msg_ready)
				pwr_msg_valid <= 1'b0;
		end
	end

	// BAR base register, zero after reset.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			bar_base <= BAR_BASE_RST;
		else if (bar_base_load)
			bar_base <= bar_base_wdata;
	end

	assign bar_mask = ~((32'h0000_0001 << BAR_SIZE_LOG2) - 32'h0000_0001);
	assign bar_hit = BAR_EN && ((rx_addr & bar_mask) == (bar_base & bar_mask));

	// Forward every packet; only hits on an enabled BAR are translated.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			fwd_valid <= 1'b0;
			fwd_addr <= '0;
			fwd_data <= '0;
		end
		else
		begin
			fwd_valid <= rx_valid;
			fwd_data <= rx_data;
			if (bar_hit && XLATE_EN)
				fwd_addr <= (xlate_base & bar_mask) | (rx_addr & ~bar_mask);
			else
				fwd_addr <= rx_addr;
		end
	end

	// Received interrupts steer to one handling path fixed at build time.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			int_fifo_push <= 1'b0;
			int_decode_set <= 1'b0;
		end
		else
		begin
			int_fifo_push <= rx_int_msg && !RX_DECODE;
			int_decode_set <= rx_int_msg && RX_DECODE;
		end
	end

	chk_local_no_link: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_LOCAL |-> !link_req_valid && loc_valid)
		else $error("Local access leaked onto the link.");

	chk_type_select: assert property (@(posedge clk) disable iff (!rst_n)
		link_req_valid |-> link_req.is_type1 == (link_req.bus != secondary_bus))
		else $error("Link request carries the wrong configuration type.");

	chk_range_error: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_ACCEPT && !in_primary && !in_type0 && !in_type1
		|=> !link_req_valid && (bvalid ? bresp == RESP_SLVERR : rresp == RESP_SLVERR))
		else $error("Out of range access did not end with SLVERR.");

	chk_ur_read_ones: assert property (@(posedge clk) disable iff (!rst_n)
		cpl_take && !is_write && cpl.status == CPL_UR |=> rvalid && rdata == ALL_ONES)
		else $error("Unsupported read did not return all ones.");

	chk_ur_write_err: assert property (@(posedge clk) disable iff (!rst_n)
		cpl_take && is_write && cpl.status == CPL_UR |=> bvalid && bresp == RESP_SLVERR)
		else $error("Unsupported write did not end with SLVERR.");

	chk_timeout_resp: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_LINK && tmr_expired && !cpl_take
		|=> state == ST_RESP && timeout_irq && (bresp == RESP_SLVERR || rresp == RESP_SLVERR))
		else $error("Timeout did not end the access with SLVERR and interrupt.");

	chk_power_msg: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(master_enable) |=> pwr_msg_valid && pwr_msg_rid == $past(requester_id))
		else $error("Master Enable did not send a power limit message.");

	chk_rx_forward: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid |=> fwd_valid && fwd_data == $past(rx_data))
		else $error("Received packet was not forwarded.");
endmodule // rpc_root_port_cfg

// *** rpc_link_model.sv ***
`timescale 1ns/100ps
module rpc_link_model
	import rpc_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Behaviour chosen by the bench.
	input wire logic [2:0] status,
	input wire logic [11:0] delay,
	input wire logic drop,
	// Link side.
	input wire logic link_req_valid,
	output logic link_req_ready,
	output logic cpl_valid,
	output rpc_pkg::rpc_cpl_t cpl,
	// Local block and power message.
	input wire logic loc_valid,
	output logic loc_ack,
	output logic [31:0] loc_rdata,
	input wire logic pwr_msg_valid,
	output logic pwr_msg_ready
);
	logic busy;
	logic [11:0] cnt;
	logic [31:0] noise;
	// Released data lines show a moving pattern so a stale value never looks valid.
	always @(posedge clk)
	begin
		noise <= rst_n ? {noise[30:0], noise[31] ^ noise[21]} : 32'h1;
		cpl_valid <= 1'b0;
		cpl <= {3'h7, ~noise};
		loc_rdata <= noise;
		loc_ack <= rst_n && loc_valid && !loc_ack;
		pwr_msg_ready <= rst_n && pwr_msg_valid && !pwr_msg_ready;
		link_req_ready <= rst_n && link_req_valid && !link_req_ready && !busy;
		if (!rst_n)
			busy <= 1'b0;
		else if (link_req_valid && link_req_ready)
		begin
			busy <= 1'b1;
			cnt <= delay;
		end
		else if (busy && cnt != 12'h0)
			cnt <= cnt - 12'h1;
		else if (busy)
		begin
			// A dropped request never completes, which is what the timer is for.
			busy <= 1'b0;
			cpl_valid <= !drop;
			cpl <= {status, 32'h600d_0000 | delay};
		end
		if (rst_n && loc_valid && !loc_ack)
			loc_rdata <= 32'h10ca_1234;
	end
endmodule // rpc_link_model

// *** root_port_config_access_bench.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module root_port_config_access_bench;
	import rpc_pkg::*;
	logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, master_enable, loc_valid, loc_ack, link_req_valid, link_req_ready;
	logic cpl_valid, timeout_irq, pwr_msg_valid, pwr_msg_ready, rx_valid, bar_base_load;
	logic fwd_valid, rx_int_msg, int_fifo_push, int_decode_set, drop;
	logic [27:0] awaddr, araddr;
	logic [31:0] wdata, rdata, loc_rdata, rx_addr, rx_data, bar_base_wdata, xlate_base;
	logic [31:0] fwd_addr, fwd_data, seed, r, last_fa, last_fd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [7:0] primary_bus, secondary_bus, subordinate_bus;
	logic [15:0] requester_id, pwr_msg_rid, last_rid;
	logic [2:0] status;
	logic [11:0] delay;
	rpc_cfg_req_t loc_req, link_req, last_req, last_loc;
	rpc_cpl_t cpl;
	int fails, num_checks, n_loc, n_link, n_tmo, n_fwd, n_fifo, n_dec, n_pwr, i;
	rpc_root_port_cfg rpc_root_port_cfg_inst (.*);
	rpc_link_model rpc_link_model_inst (.*);
	// Clock at 40 MHz.
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Xorshift source with a fixed start, so every run is the same.
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Counts events at the edge where they are taken, before the design updates.
	always @(posedge clk)
	begin
		if (rst_n)
		begin
			if (loc_valid && loc_ack)
			begin
				n_loc++;
				last_loc = loc_req;
			end
			n_tmo += timeout_irq;
			n_fifo += int_fifo_push;
			n_dec += int_decode_set;
			if (link_req_valid && link_req_ready)
			begin
				n_link++;
				last_req = link_req;
			end
			if (fwd_valid)
			begin
				n_fwd++;
				last_fa = fwd_addr;
				last_fd = fwd_data;
			end
			if (pwr_msg_valid && pwr_msg_ready)
			begin
				n_pwr++;
				last_rid = pwr_msg_rid;
			end
		end
	end
	// One configuration access; expectations come from the bus numbers and the link model settings.
	task automatic access(input logic we, input logic [27:0] a);
		int dest, k, l0, k0, t0;
		logic [1:0] er;
		logic [31:0] ed, eh;
		logic [7:0] b;
		b = a[27:20];
		dest = (b == primary_bus) ? 1 : (b == secondary_bus) ? 2 : 0;
		if (b > secondary_bus && b <= subordinate_bus)
			dest = 3;
		er = RESP_OKAY;
		ed = 32'h10ca_1234;
		if (dest == 0 || (dest > 1 && (drop || status != CPL_SC)))
		begin
			er = RESP_SLVERR;
			ed = ALL_ONES;
		end
		if (dest > 1 && !drop && status == CPL_SC)
			ed = 32'h600d_0000 | delay;
		if (dest > 1 && !drop && status == CPL_UR && !we)
			er = RESP_OKAY;
		l0 = n_link;
		k0 = n_loc;
		t0 = n_tmo;
		r = rnd();
		wdata = r;
		wstrb = r[3:0];
		awaddr = a;
		araddr = a;
		awvalid = we;
		wvalid = we;
		arvalid = !we;
		for (k = 0; k < 50 && !(arready || awready); k++)
			@(negedge clk);
		// An access that is never taken is a hang, not a quiet skip.
		if (k == 50)
		begin
			fails++;
			close_out();
		end
		@(negedge clk);
		{arvalid, awvalid, wvalid} = 3'h0;
		for (k = 0; k < 3000 && !(rvalid || bvalid); k++)
			@(negedge clk);
		if (k == 3000)
		begin
			fails++;
			close_out();
		end
		`CHK("resp", er, we ? bresp : rresp)
		if (!we)
			`CHK("rdata", ed, rdata)
		{bready, rready} = 2'h3;
		@(negedge clk);
		{bready, rready} = 2'h0;
		repeat (2) @(negedge clk);
		`CHK("local", k0 + (dest == 1), n_loc)
		`CHK("link", l0 + (dest > 1), n_link)
		`CHK("timeouts", t0 + (dest > 1 && drop), n_tmo)
		// Header of the request that should have been issued, type bit first.
		eh = {dest == 3, we, a[27:12], a[11:2], we ? wstrb : 4'hf};
		if (dest > 1)
			`CHK("req", eh, last_req[63:32])
		if (dest > 1 && we)
			`CHK("wdata", wdata, last_req.data)
		if (dest == 1)
			`CHK("loc req", eh, last_loc[63:32])
		if (dest == 1 && we)
			`CHK("loc wdata", wdata, last_loc.data)
	endtask
	// Main sequence.
	initial
	begin
		seed = 32'hb337;
		rst_n = 1'b0;
		{awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, wstrb} = '0;
		{master_enable, requester_id, rx_valid, rx_addr, rx_data, bar_base_load} = '0;
		{bar_base_wdata, xlate_base, rx_int_msg, status, delay, drop} = '0;
		primary_bus = 8'h00;
		secondary_bus = 8'h01;
		subordinate_bus = 8'h04;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		// Bus numbers swept at the range edges first, then drawn at random.
		for (i = 0; i < 40; i++)
		begin
			r = rnd();
			status = (r[1:0] == 2'h0) ? CPL_UR : (r[1:0] == 2'h1) ? 3'h4 : CPL_SC;
			delay = {8'h0, r[7:4]};
			access(r[2], {(i < 6) ? i[7:0] : 8'(r[10:8] % 3'h7), r[27:8]});
		end
		// Completions that never come.
		drop = 1'b1;
		access(1'b0, 28'h020_0104);
		access(1'b1, 28'h030_0104);
		drop = 1'b0;
		// Requester identity set before Master Enable.
		r = rnd();
		requester_id = r[15:0];
		@(negedge clk);
		master_enable = 1'b1;
		repeat (6) @(negedge clk);
		`CHK("pwr count", 1, n_pwr)
		`CHK("pwr rid", requester_id, last_rid)
		// Received packets stay inside the aperture; the base moves halfway.
		for (i = 0; i < 20; i++)
		begin
			if (i == 10)
			begin
				bar_base_wdata = 32'h4010_0000;
				bar_base_load = 1'b1;
				@(negedge clk);
				bar_base_load = 1'b0;
			end
			r = rnd();
			xlate_base = rnd();
			rx_addr = {(i < 10) ? 12'h000 : 12'h401, r[19:0]};
			rx_data = rnd();
			rx_valid = 1'b1;
			@(negedge clk);
			rx_valid = 1'b0;
			repeat (2) @(negedge clk);
			`CHK("fwd count", i + 1, n_fwd)
			`CHK("fwd addr", {xlate_base[31:20], rx_addr[19:0]}, last_fa)
			`CHK("fwd data", rx_data, last_fd)
		end
		// Received interrupts take the default FIFO path.
		for (i = 0; i < 3; i++)
		begin
			rx_int_msg = 1'b1;
			@(negedge clk);
			rx_int_msg = 1'b0;
			@(negedge clk);
		end
		@(negedge clk);
		`CHK("fifo push", 3, n_fifo)
		`CHK("decode set", 0, n_dec)
		close_out();
	end
endmodule // root_port_config_access_bench
